/* File: verilog/csr_core.sv */
// core datapath: alu, status flags, register file and stack pointer
//
// Summary of operation
// RULE1: alu finishes a reg-reg or reg-immediate operation in one clock
// RULE2: status flags are updated after every alu operation
// RULE3: status flags are never saved or restored on interrupt entry or exit
// RULE4: interrupts are blocked whenever global enable bit 7 is zero
// RULE5: enable bit cleared on interrupt taken, set by return or set insn
// RULE6: bit 6 holds one bit moved by bit store and bit load
// RULE7: bit 5 reports carry out of the low nibble
// RULE8: bit 4 always equals negative xor overflow
// RULE9: bit 3 reports two's complement overflow
// RULE10: bit 2 set when the result is negative
// RULE11: bit 1 set when the result is zero
// RULE12: bit 0 reports carry from the operation
// RULE13: register file serves 8/8, two 8/8, two 8/16 and 16/16 patterns
// RULE14: register n appears at data address n, 0x00 to 0x1f
// RULE15: registers 26 to 31 form three pointers, low byte even
// RULE16: pointers support displacement, post increment and pre decrement
// RULE17: stack grows down; push decrements by one, pop increments by one
// RULE18: call or interrupt subtracts two; returns add two
// RULE19: program must load stack pointer above 0x0100 before calls
// RULE20: stack pointer is two rw i/o registers reset to sram top
// RULE21: core runs directly on the incoming clock, no division
// RULE22: pointer into register-file range reaches the working register
// RULE23: next instruction fetch overlaps execution, one per clock
// RULE24: sram top address is a design parameter
`timescale 1ns/1ps
module csr_core
  import csr_pkg::*;
#(
  parameter logic [15:0] SRAM_TOP = SRAM_TOP_DEFAULT // RULE24
) (
  // clock and reset, core clock used undivided
  input wire logic mclk_i,
  input wire logic nrst_i,
  // alu request
  input wire csr_alu_req_type alu_req_i,
  // flag control
  input wire csr_gie_op_type gie_op_i,
  input wire csr_bit_req_type bit_req_i,
  input wire logic irq_pending_i,
  // pointer access
  input wire csr_ptr_req_type ptr_req_i,
  // data-space access
  input wire csr_ds_req_type ds_req_i,
  // stack event
  input wire csr_stk_op_type stk_op_i,
  // instruction fetch handshake
  input wire logic [15:0] fetch_word_i,
  // outputs
  output logic [7:0] status_flags_o,
  output logic [15:0] stack_pointer_o,
  output logic irq_take_o,
  output logic [7:0] result_o,
  output logic [15:0] ptr_addr_o,
  output logic [7:0] ds_rdata_o,
  output logic ds_hit_o,
  output logic [15:0] insn_o
);

  initial if (SRAM_TOP <= 16'h0100) $error("sram top must lie above 0x0100");

  // core state other than the register file copies in one struct
  typedef struct packed {
    logic [7:0] flags;
    logic [15:0] sp;
    logic irq_take;
    logic [7:0] result;
    logic [15:0] ptr_addr;
    logic [7:0] ds_rdata;
    logic ds_hit;
    logic [15:0] insn;
  } csr_core_state_type;

  csr_core_state_type st_r;
  csr_core_state_type st_nxt;

  // register file ports
  logic [7:0] rf_a;
  logic [7:0] rf_b;
  logic rf_we;
  logic [4:0] rf_wa;
  logic [7:0] rf_wd;
  logic rf_we16;
  logic [4:0] rf_wa16;
  logic [15:0] rf_wd16;
  logic [7:0] shadow_r [NUM_REGS];
  csr_alu_res_type alu_res;

  // decodes a data-space address into the register-file window
  function automatic logic in_regfile(input logic [15:0] a);
    in_regfile = (a <= REGFILE_LAST); // RULE14 RULE22
  endfunction : in_regfile

  // pointer base register index from selector
  function automatic logic [4:0] ptr_base(input logic [1:0] s);
    case (s)
      2'd0: ptr_base = PTR_X_LO;
      2'd1: ptr_base = PTR_Y_LO;
      default: ptr_base = PTR_Z_LO;
    endcase // RULE15
  endfunction : ptr_base

  // combinational shadow keeps same-cycle operand reads; the registered
  // file ports would add a cycle and break single-cycle execution
  csr_regfile #(.N(NUM_REGS)) u_rf (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ra_i(alu_req_i.rd),
    .rb_i(alu_req_i.rr),
    .da_o(rf_a),
    .db_o(rf_b),
    .we_i(rf_we),
    .wa_i(rf_wa),
    .wd_i(rf_wd),
    .we16_i(rf_we16),
    .wa16_i(rf_wa16),
    .wd16_i(rf_wd16)
  );

  // shadow copy giving combinational operand access
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_REGS; i++) shadow_r[i] <= 8'h00;
    end else begin
      if (rf_we) shadow_r[rf_wa] <= rf_wd;
      if (rf_we16) begin // RULE13
        shadow_r[{rf_wa16[4:1], 1'b0}] <= rf_wd16[7:0];
        shadow_r[{rf_wa16[4:1], 1'b1}] <= rf_wd16[15:8];
      end
    end
  end

  logic [7:0] opa;
  logic [7:0] opb;
  assign opa = shadow_r[alu_req_i.rd];
  assign opb = alu_req_i.use_imm ? alu_req_i.imm : shadow_r[alu_req_i.rr];

  csr_alu u_alu (
    .op_i(alu_req_i.op),
    .a_i(opa),
    .b_i(opb),
    .cin_i(st_r.flags[FLG_C]),
    .res_o(alu_res)
  ); // RULE1

  logic [15:0] ptr_val;
  logic [4:0] pb;
  assign pb = ptr_base(ptr_req_i.sel);
  assign ptr_val = {shadow_r[{pb[4:1], 1'b1}], shadow_r[{pb[4:1], 1'b0}]};

  // next-state logic for flags, stack pointer, pointers and writes
  always_comb begin
    logic [7:0] r;
    logic [7:0] bv;
    logic n;
    logic v;
    r = alu_res.res;
    bv = 8'h00;
    n = 1'b0;
    v = 1'b0;
    st_nxt = st_r;
    st_nxt.irq_take = 1'b0;
    st_nxt.ds_hit = 1'b0;
    st_nxt.insn = fetch_word_i; // RULE23
    rf_we = 1'b0;
    rf_wa = 5'h00;
    rf_wd = 8'h00;
    rf_we16 = 1'b0;
    rf_wa16 = 5'h00;
    rf_wd16 = 16'h0000;

    // alu write-back and flag update; interrupt entry changes only flag bit 7
    if (alu_req_i.valid) begin // RULE2 RULE3
      n = r[7];
      v = alu_res.v;
      st_nxt.flags[FLG_C] = alu_res.c; // RULE12
      st_nxt.flags[FLG_Z] = (r == 8'h00); // RULE11
      st_nxt.flags[FLG_N] = n; // RULE10
      st_nxt.flags[FLG_V] = v; // RULE9
      st_nxt.flags[FLG_S] = n ^ v; // RULE8
      st_nxt.flags[FLG_H] = alu_res.h; // RULE7
      st_nxt.result = r;
      rf_we = 1'b1;
      rf_wa = alu_req_i.rd;
      rf_wd = r;
    end

    // bit transfer through bit 6
    if (bit_req_i.store) begin
      bv = shadow_r[bit_req_i.reg_idx];
      st_nxt.flags[FLG_T] = bv[bit_req_i.bit_idx]; // RULE6
    end else if (bit_req_i.load && !rf_we) begin
      bv = shadow_r[bit_req_i.reg_idx];
      bv[bit_req_i.bit_idx] = st_r.flags[FLG_T]; // RULE6
      rf_we = 1'b1;
      rf_wa = bit_req_i.reg_idx;
      rf_wd = bv;
    end

    // global interrupt enable, taking only while bit 7 is set
    st_nxt.irq_take = irq_pending_i && st_r.flags[FLG_I]
                      && (gie_op_i != CSR_GIE_CLEAR); // RULE4
    case (gie_op_i)
      CSR_GIE_SET, CSR_GIE_IRQ_RETURN_INSN: st_nxt.flags[FLG_I] = 1'b1; // RULE5
      CSR_GIE_CLEAR, CSR_GIE_TAKEN: st_nxt.flags[FLG_I] = 1'b0; // RULE5
      default: ;
    endcase

    // pointer addressing with post increment and pre decrement
    if (ptr_req_i.valid) begin
      case (ptr_req_i.mode)
        CSR_PTR_DISP: st_nxt.ptr_addr = ptr_val + {10'h000, ptr_req_i.disp};
        CSR_PTR_POSTINC: begin
          st_nxt.ptr_addr = ptr_val;
          rf_we16 = 1'b1;
          rf_wd16 = ptr_val + 16'h0001; // RULE16
        end
        CSR_PTR_PREDEC: begin
          st_nxt.ptr_addr = ptr_val - 16'h0001;
          rf_we16 = 1'b1;
          rf_wd16 = ptr_val - 16'h0001; // RULE16
        end
        default: st_nxt.ptr_addr = ptr_val;
      endcase
      rf_wa16 = pb;
    end

    // stack pointer movement, downward growth
    case (stk_op_i)
      CSR_STK_PUSH: st_nxt.sp = st_r.sp - 16'h0001; // RULE17
      CSR_STK_POP: st_nxt.sp = st_r.sp + 16'h0001; // RULE17
      CSR_STK_CALL: st_nxt.sp = st_r.sp - 16'h0002; // RULE18
      CSR_STK_RET: st_nxt.sp = st_r.sp + 16'h0002; // RULE18
      default: ;
    endcase

    // data-space view of registers and stack pointer bytes
    if (ds_req_i.rd_en || ds_req_i.wr_en) begin
      if (in_regfile(ds_req_i.addr)) begin // RULE14 RULE22
        st_nxt.ds_hit = 1'b1;
        st_nxt.ds_rdata = shadow_r[ds_req_i.addr[4:0]];
        if (ds_req_i.wr_en && !rf_we) begin
          rf_we = 1'b1;
          rf_wa = ds_req_i.addr[4:0];
          rf_wd = ds_req_i.wdata;
        end
      end else if (ds_req_i.addr == DS_SP_LOW) begin // RULE20
        st_nxt.ds_hit = 1'b1;
        st_nxt.ds_rdata = st_r.sp[7:0];
        if (ds_req_i.wr_en) st_nxt.sp[7:0] = ds_req_i.wdata;
      end else if (ds_req_i.addr == DS_SP_HIGH) begin // RULE20
        st_nxt.ds_hit = 1'b1;
        st_nxt.ds_rdata = st_r.sp[15:8];
        if (ds_req_i.wr_en) st_nxt.sp[15:8] = ds_req_i.wdata;
      end else st_nxt.ds_rdata = 8'h00;
    end
  end

  // single state register on the undivided core clock
  always_ff @(posedge mclk_i or negedge nrst_i) begin // RULE21
    if (!nrst_i) begin
      st_r <= '{flags: STATUS_RESET, sp: SRAM_TOP, default: '0}; // RULE20
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status_flags_o = st_r.flags;
  assign stack_pointer_o = st_r.sp;
  assign irq_take_o = st_r.irq_take;
  assign result_o = st_r.result;
  assign ptr_addr_o = st_r.ptr_addr;
  assign ds_rdata_o = st_r.ds_rdata;
  assign ds_hit_o = st_r.ds_hit;
  assign insn_o = st_r.insn;

  // properties
  property p_sign_rel;
    @(posedge mclk_i) disable iff (!nrst_i)
      status_flags_o[FLG_S] == (status_flags_o[FLG_N] ^ status_flags_o[FLG_V]);
  endproperty
  a_sign_rel: assert property (p_sign_rel) else $error("bad sign"); // RULE8
  property p_push;
    @(posedge mclk_i) disable iff (!nrst_i)
      (stk_op_i == CSR_STK_PUSH && !ds_req_i.wr_en)
        |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push step wrong"); // RULE17
  property p_call;
    @(posedge mclk_i) disable iff (!nrst_i)
      (stk_op_i == CSR_STK_CALL && !ds_req_i.wr_en)
        |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0002;
  endproperty
  a_call: assert property (p_call) else $error("call step wrong"); // RULE18
  property p_ret;
    @(posedge mclk_i) disable iff (!nrst_i)
      (stk_op_i == CSR_STK_RET && !ds_req_i.wr_en)
        |=> stack_pointer_o == $past(stack_pointer_o) + 16'h0002;
  endproperty
  a_ret: assert property (p_ret) else $error("return step wrong"); // RULE18
  property p_gie_block;
    @(posedge mclk_i) disable iff (!nrst_i)
      !status_flags_o[FLG_I] |=> !irq_take_o;
  endproperty
  a_gie_block: assert property (p_gie_block) else $error("irq taken"); // RULE4
  property p_gie_clear;
    @(posedge mclk_i) disable iff (!nrst_i)
      gie_op_i == CSR_GIE_TAKEN |=> !status_flags_o[FLG_I];
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("gie kept"); // RULE5
  property p_zero;
    @(posedge mclk_i) disable iff (!nrst_i)
      alu_req_i.valid |=> status_flags_o[FLG_Z] == (result_o == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE11
  property p_neg;
    @(posedge mclk_i) disable iff (!nrst_i)
      alu_req_i.valid |=> status_flags_o[FLG_N] == result_o[7];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong"); // RULE10
  property p_flags_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      (!alu_req_i.valid && !bit_req_i.store && gie_op_i == CSR_GIE_NONE)
        |=> $stable(status_flags_o);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // RULE3
    else $error("flags moved");
  // registered file ports trail the shadow copy by one cycle
  property p_rf_mirror;
    @(posedge mclk_i) disable iff (!nrst_i)
      {rf_a, rf_b} == $past({opa, shadow_r[alu_req_i.rr]});
  endproperty
  a_rf_mirror: assert property (p_rf_mirror) else $error("rf copy"); // RULE13
  c_call: cover property (@(posedge mclk_i) stk_op_i == CSR_STK_CALL);
  c_irq: cover property (@(posedge mclk_i) irq_take_o);
  c_alu: cover property (@(posedge mclk_i) alu_req_i.valid ##3 ds_hit_o);
endmodule : csr_core

/* File: verilog/csr_pkg.sv */
// package for the core datapath: constants, enums and carrier structs
package csr_pkg;

  // data width and register file geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int NUM_REGS = 32;
  localparam int REG_IDX_W = 5;

  // data-space placement of the working registers
  localparam logic [15:0] REGFILE_BASE = 16'h0000;
  localparam logic [15:0] REGFILE_LAST = 16'h001f;

  // pointer pair base indices (low byte even, high byte odd)
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // stack pointer i/o offsets and data-space aliases
  localparam logic [5:0] IO_SP_LOW = 6'h3d;
  localparam logic [5:0] IO_SP_HIGH = 6'h3e;
  localparam logic [15:0] DS_SP_LOW = 16'h005d;
  localparam logic [15:0] DS_SP_HIGH = 16'h005e;

  // default top of data memory, used as stack pointer reset value
  localparam logic [15:0] SRAM_TOP_DEFAULT = 16'h04ff;

  // status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // alu operations
  typedef enum logic [3:0] {
    CSR_OP_ADD, CSR_OP_ADC, CSR_OP_SUB, CSR_OP_SBC,
    CSR_OP_AND, CSR_OP_OR, CSR_OP_XOR, CSR_OP_COM,
    CSR_OP_NEG, CSR_OP_INC, CSR_OP_DEC, CSR_OP_LSR,
    CSR_OP_ROR, CSR_OP_ASR, CSR_OP_SWAP, CSR_OP_MOV
  } csr_alu_op_type;

  // stack events
  typedef enum logic [2:0] {
    CSR_STK_NONE, CSR_STK_PUSH, CSR_STK_POP,
    CSR_STK_CALL, CSR_STK_RET
  } csr_stk_op_type;

  // pointer access modes
  typedef enum logic [1:0] {
    CSR_PTR_DISP, CSR_PTR_POSTINC, CSR_PTR_PREDEC
  } csr_ptr_mode_type;

  // global interrupt enable events
  typedef enum logic [2:0] {
    CSR_GIE_NONE, CSR_GIE_SET, CSR_GIE_CLEAR, CSR_GIE_TAKEN,
    CSR_GIE_IRQ_RETURN_INSN
  } csr_gie_op_type;

  // alu request from decode
  typedef struct packed {
    logic valid;
    csr_alu_op_type op;
    logic use_imm;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
  } csr_alu_req_type;

  // pointer access request from decode
  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    csr_ptr_mode_type mode;
    logic [5:0] disp;
  } csr_ptr_req_type;

  // data-space access request from decode
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [7:0] wdata;
  } csr_ds_req_type;

  // bit transfer request
  typedef struct packed {
    logic store;
    logic load;
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;
  } csr_bit_req_type;

  // alu result as seen by the core
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic h;
    logic v;
  } csr_alu_res_type;

endpackage : csr_pkg

/* File: verilog/csr_regfile.sv */
// 32 x 8 working register file with two read ports and a 16-bit write
`timescale 1ns/1ps
module csr_regfile
  import csr_pkg::*;
#(
  parameter int N = NUM_REGS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // read ports, registered data
  input wire logic [4:0] ra_i,
  input wire logic [4:0] rb_i,
  output logic [7:0] da_o,
  output logic [7:0] db_o,
  // byte write and word write (idx even for word)
  input wire logic we_i,
  input wire logic [4:0] wa_i,
  input wire logic [7:0] wd_i,
  input wire logic we16_i,
  input wire logic [4:0] wa16_i,
  input wire logic [15:0] wd16_i
);

  initial begin
    if (N != 32) $error("register file must hold 32 entries");
  end

  logic [7:0] mem_r [N];
  logic [7:0] da_r;
  logic [7:0] db_r;

  // storage: word write lands low byte even, high byte odd
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < N; i++) mem_r[i] <= 8'h00;
      da_r <= 8'h00;
      db_r <= 8'h00;
    end else begin
      if (we_i) mem_r[wa_i] <= wd_i;
      if (we16_i) begin
        mem_r[{wa16_i[4:1], 1'b0}] <= wd16_i[7:0];
        mem_r[{wa16_i[4:1], 1'b1}] <= wd16_i[15:8];
      end
      da_r <= mem_r[ra_i];
      db_r <= mem_r[rb_i];
    end
  end

  assign da_o = da_r;
  assign db_o = db_r;

endmodule : csr_regfile

/* File: verilog/csr_alu.sv */
// combinational 8-bit alu producing result, carry, half carry, overflow
`timescale 1ns/1ps
module csr_alu
  import csr_pkg::*;
(
  // operands
  input wire csr_alu_op_type op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  // result
  output csr_alu_res_type res_o
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] r;
  logic c;
  logic h;
  logic v;

  // one pass, no state: the whole op fits in one core cycle
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    r = 8'h00;
    c = 1'b0;
    h = 1'b0;
    v = 1'b0;
    case (op_i)
      CSR_OP_ADD, CSR_OP_ADC: begin
        sum = {1'b0, a_i} + {1'b0, b_i}
              + {8'h00, cin_i & (op_i == CSR_OP_ADC)};
        nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}
              + {4'h0, cin_i & (op_i == CSR_OP_ADC)};
        r = sum[7:0];
        c = sum[8];
        h = nib[4];
        v = (a_i[7] == b_i[7]) && (r[7] != a_i[7]);
      end
      CSR_OP_SUB, CSR_OP_SBC, CSR_OP_NEG: begin
        if (op_i == CSR_OP_NEG) begin
          sum = 9'h000 - {1'b0, a_i};
          nib = 5'h00 - {1'b0, a_i[3:0]};
          r = sum[7:0];
          v = (a_i[7] && !r[7]) ? 1'b0 : (a_i == 8'h80);
        end else begin
          sum = {1'b0, a_i} - {1'b0, b_i}
                - {8'h00, cin_i & (op_i == CSR_OP_SBC)};
          nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]}
                - {4'h0, cin_i & (op_i == CSR_OP_SBC)};
          r = sum[7:0];
          v = (a_i[7] != b_i[7]) && (r[7] != a_i[7]);
        end
        c = sum[8];
        h = nib[4];
      end
      CSR_OP_AND: r = a_i & b_i;
      CSR_OP_OR: r = a_i | b_i;
      CSR_OP_XOR: r = a_i ^ b_i;
      CSR_OP_COM: begin
        r = ~a_i;
        c = 1'b1;
      end
      CSR_OP_INC: begin
        r = a_i + 8'h01;
        c = cin_i;
        v = (a_i == 8'h7f);
      end
      CSR_OP_DEC: begin
        r = a_i - 8'h01;
        c = cin_i;
        v = (a_i == 8'h80);
      end
      CSR_OP_LSR, CSR_OP_ROR, CSR_OP_ASR: begin
        if (op_i == CSR_OP_LSR) r = {1'b0, a_i[7:1]};
        else if (op_i == CSR_OP_ROR) r = {cin_i, a_i[7:1]};
        else r = {a_i[7], a_i[7:1]};
        c = a_i[0];
        v = r[7] ^ a_i[0];
      end
      CSR_OP_SWAP: begin
        r = {a_i[3:0], a_i[7:4]};
        c = cin_i;
      end
      CSR_OP_MOV: begin
        r = b_i;
        c = cin_i;
      end
      default: r = a_i;
    endcase
    res_o = '{res: r, c: c, h: h, v: v};
  end

endmodule : csr_alu

/* File: bench/csr_dec_model.sv */
// decode model: issues one request kind per cycle into the core
`timescale 1ns/1ps
module csr_dec_model
  import csr_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // request ports of the core
  output csr_alu_req_type alu_req_o,
  output csr_gie_op_type gie_op_o,
  output csr_bit_req_type bit_req_o,
  output logic irq_pending_o,
  output csr_ptr_req_type ptr_req_o,
  output csr_ds_req_type ds_req_o,
  output csr_stk_op_type stk_op_o,
  output logic [15:0] fetch_word_o
);
  // all requests idle from time zero
  initial begin
    alu_req_o = '0;
    gie_op_o = CSR_GIE_NONE;
    bit_req_o = '0;
    irq_pending_o = 1'b0;
    ptr_req_o = '0;
    ds_req_o = '0;
    stk_op_o = CSR_STK_NONE;
    fetch_word_o = 16'h0000;
  end
  // launch point just after a rising edge
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask : step
  // idle cycles, so the model can also answer slowly
  task automatic idle(input int n);
    repeat (n) step();
  endtask : idle
  // alu request with destination and source register indices
  task automatic alu(input csr_alu_op_type op, input logic ui,
      input logic [7:0] imm, input logic [4:0] rd, input logic [4:0] rr);
    step();
    alu_req_o = '{1'b1, op, ui, rd, rr, imm};
    step();
    alu_req_o = '{1'b0, op, 1'b0, rd, rr, ~imm}; // stale value scrambled
  endtask : alu
  // data-space access; released bus carries inverted address and data
  task automatic ds(input logic wr, input logic [15:0] a,
      input logic [7:0] d);
    step();
    ds_req_o = '{~wr, wr, a, d};
    step();
    ds_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask : ds
  // global enable event
  task automatic gie(input csr_gie_op_type op);
    step();
    gie_op_o = op;
    step();
    gie_op_o = CSR_GIE_NONE;
  endtask : gie
  // stack event
  task automatic stk(input csr_stk_op_type op);
    step();
    stk_op_o = op;
    step();
    stk_op_o = CSR_STK_NONE;
  endtask : stk
  // pointer access
  task automatic ptr(input logic [1:0] sel, input csr_ptr_mode_type m,
      input logic [5:0] d);
    step();
    ptr_req_o = '{1'b1, sel, m, d};
    step();
    ptr_req_o = '{1'b0, sel, m, ~d};
  endtask : ptr
  // bit store when st is high, bit load otherwise
  task automatic bits(input logic st, input logic [4:0] r,
      input logic [2:0] b);
    step();
    bit_req_o = '{st, ~st, r, b};
    step();
    bit_req_o = '0;
  endtask : bits
  // pending level and next instruction word
  task automatic pend(input logic v);
    step();
    irq_pending_o = v;
  endtask : pend
  task automatic fetch(input logic [15:0] w);
    step();
    fetch_word_o = w;
  endtask : fetch
endmodule : csr_dec_model

/* File: bench/cpu_status_regfile_stack_tb_top.sv */
// self-checking bench for the core datapath
`timescale 1ns/1ps
module cpu_status_regfile_stack_tb_top
  import csr_pkg::*;
;
  // stack reset value moved off the default to exercise the parameter
  localparam logic [15:0] SP_TOP = 16'h08ff;
  // alu table row: operands, result, flags under mask
  typedef struct packed {
    csr_alu_op_type op;
    logic ui;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] res;
    logic [7:0] flg;
    logic [7:0] msk;
  } csr_row_type;
  // and, or and xor force carry and half carry to zero; those are masked
  csr_row_type rows [10] = '{
    '{CSR_OP_ADD, 1'b0, 8'h7f, 8'h01, 8'h80, 8'h2c, 8'h3f},
    '{CSR_OP_ADD, 1'b0, 8'hff, 8'h01, 8'h00, 8'h23, 8'h3f},
    '{CSR_OP_SUB, 1'b0, 8'h00, 8'h01, 8'hff, 8'h35, 8'h3f},
    '{CSR_OP_SUB, 1'b1, 8'h80, 8'h01, 8'h7f, 8'h38, 8'h3f},
    '{CSR_OP_AND, 1'b0, 8'hf0, 8'h0f, 8'h00, 8'h02, 8'h1e},
    '{CSR_OP_XOR, 1'b0, 8'h80, 8'h01, 8'h81, 8'h14, 8'h1e},
    '{CSR_OP_INC, 1'b0, 8'h7f, 8'h00, 8'h80, 8'h0c, 8'h1e},
    '{CSR_OP_NEG, 1'b0, 8'h01, 8'h00, 8'hff, 8'h35, 8'h3f},
    '{CSR_OP_LSR, 1'b0, 8'h01, 8'h00, 8'h00, 8'h1b, 8'h1f},
    // adc right after the shift consumes the carry it left
    '{CSR_OP_ADC, 1'b0, 8'h01, 8'h01, 8'h03, 8'h00, 8'h3f}
  };
  csr_gie_op_type gops [4] = '{CSR_GIE_SET, CSR_GIE_TAKEN, CSR_GIE_IRQ_RETURN_INSN,
    CSR_GIE_CLEAR};
  logic [7:0] gexp [4] = '{8'hac, 8'h2c, 8'hac, 8'h2c};
  csr_stk_op_type sops [4] = '{CSR_STK_CALL, CSR_STK_RET, CSR_STK_PUSH,
    CSR_STK_POP};
  logic [15:0] sexp [4] = '{16'h0ffe, 16'h1000, 16'h0fff, 16'h1000};
  logic mclk;
  logic nrst;
  int miscompares = 0;
  int checks_done = 0;
  csr_alu_req_type alu_req;
  csr_gie_op_type gie_op;
  csr_bit_req_type bit_req;
  logic irq_pend;
  csr_ptr_req_type ptr_req;
  csr_ds_req_type ds_req;
  csr_stk_op_type stk_op;
  logic [15:0] fetch_word;
  logic [7:0] flags;
  logic [15:0] sp;
  logic irq_take;
  logic [7:0] result;
  logic [15:0] ptr_addr;
  logic [7:0] ds_rdata;
  logic ds_hit;
  logic [15:0] insn;
  // device under test
  csr_core #(.SRAM_TOP(SP_TOP)) csr_core_i (.mclk_i(mclk), .nrst_i(nrst),
    .alu_req_i(alu_req), .gie_op_i(gie_op), .bit_req_i(bit_req),
    .irq_pending_i(irq_pend), .ptr_req_i(ptr_req), .ds_req_i(ds_req),
    .stk_op_i(stk_op), .fetch_word_i(fetch_word), .status_flags_o(flags),
    .stack_pointer_o(sp), .irq_take_o(irq_take), .result_o(result),
    .ptr_addr_o(ptr_addr), .ds_rdata_o(ds_rdata), .ds_hit_o(ds_hit),
    .insn_o(insn));
  // decode side model
  csr_dec_model csr_dec_model_i (.mclk_i(mclk), .alu_req_o(alu_req),
    .gie_op_o(gie_op), .bit_req_o(bit_req), .irq_pending_o(irq_pend),
    .ptr_req_o(ptr_req), .ds_req_o(ds_req), .stk_op_o(stk_op),
    .fetch_word_o(fetch_word));
  // 200 mhz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string n, input logic [15:0] got,
      input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  // source reg gets the inverted operand on immediate rows to catch a wrong
  // source; each row uses its own register pair, clear of r3, r4, pointers
  task automatic run_row(input int i);
    csr_row_type r;
    logic [7:0] f;
    logic [4:0] d;
    logic [4:0] s;
    r = rows[i];
    d = 5'(i + 5);
    s = 5'(i + 15);
    csr_dec_model_i.ds(1'b1, 16'(d), r.a);
    csr_dec_model_i.ds(1'b1, 16'(s), r.ui ? ~r.b : r.b);
    csr_dec_model_i.alu(r.op, r.ui, r.b, d, s);
    f = flags & r.msk;
    check("result", 16'(result), 16'(r.res));
    check("nzvc", 16'(f[3:0]), 16'(r.flg[3:0]));
    check("hs", 16'(f[5:4]), 16'(r.flg[5:4]));
    csr_dec_model_i.ds(1'b0, 16'(d), 8'h00);
    check("rd", 16'(ds_rdata), 16'(r.res));
  endtask : run_row
  // run is under two hundred cycles; this is far beyond it
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    check("sp", sp, SP_TOP);
    check("flags", 16'(flags), 16'h0000);
    foreach (rows[i]) run_row(i);
    // known low flags 0x2c before the enable sequence
    run_row(0);
    csr_dec_model_i.pend(1'b1);
    csr_dec_model_i.idle(1);
    check("irq", 16'(irq_take), 16'h0000);
    foreach (gops[i]) begin
      csr_dec_model_i.gie(gops[i]);
      check("gie", 16'(flags), 16'(gexp[i]));
      csr_dec_model_i.idle(1);
      check("irq", 16'(irq_take), 16'(gexp[i][7]));
    end
    csr_dec_model_i.pend(1'b0);
    csr_dec_model_i.ds(1'b1, 16'h0003, 8'h04);
    csr_dec_model_i.bits(1'b1, 5'h03, 3'h2);
    check("tbit", 16'(flags[FLG_T]), 16'h0001);
    csr_dec_model_i.bits(1'b0, 5'h04, 3'h7);
    csr_dec_model_i.ds(1'b0, 16'h0004, 8'h00);
    check("bld", 16'(ds_rdata), 16'h0080);
    // stack placed above 0x0100 before any call
    csr_dec_model_i.ds(1'b1, DS_SP_HIGH, 8'h10);
    csr_dec_model_i.ds(1'b1, DS_SP_LOW, 8'h00);
    check("sp", sp, 16'h1000);
    foreach (sops[i]) begin
      csr_dec_model_i.stk(sops[i]);
      check("sp", sp, sexp[i]);
    end
    csr_dec_model_i.ds(1'b0, DS_SP_HIGH, 8'h00);
    check("sph", {7'h00, ds_hit, ds_rdata}, 16'h0110);
    csr_dec_model_i.ds(1'b0, 16'h0040, 8'h00);
    check("miss", {7'h00, ds_hit, ds_rdata}, 16'h0000);
    // increment must carry into the odd high byte
    csr_dec_model_i.ds(1'b1, 16'h001e, 8'hff);
    csr_dec_model_i.ptr(2'd2, CSR_PTR_POSTINC, 6'h00);
    check("zinc", ptr_addr, 16'h00ff);
    csr_dec_model_i.ds(1'b0, 16'h001f, 8'h00);
    check("zhi", 16'(ds_rdata), 16'h0001);
    csr_dec_model_i.ptr(2'd2, CSR_PTR_PREDEC, 6'h00);
    check("zdec", ptr_addr, 16'h00ff);
    csr_dec_model_i.ptr(2'd2, CSR_PTR_DISP, 6'h3f);
    check("zdisp", ptr_addr, 16'h013e);
    csr_dec_model_i.ds(1'b1, 16'h001a, 8'h05);
    csr_dec_model_i.ptr(2'd0, CSR_PTR_DISP, 6'h00);
    check("x", ptr_addr, 16'h0005);
    csr_dec_model_i.ds(1'b1, 16'h001d, 8'h02);
    csr_dec_model_i.ptr(2'd1, CSR_PTR_DISP, 6'h21);
    check("y", ptr_addr, 16'h0221);
    csr_dec_model_i.fetch(16'ha5c3);
    csr_dec_model_i.idle(1);
    check("insn", insn, 16'ha5c3);
    // second reset in mid-run
    nrst = 1'b0;
    @(posedge mclk);
    #1;
    nrst = 1'b1;
    check("sp", sp, SP_TOP);
    check("flags", 16'(flags), 16'h0000);
    finish_test();
  end
endmodule : cpu_status_regfile_stack_tb_top
